/* File: pkg/orient_regs.svh */
`ifndef ORIENT_REGS_SVH
`define ORIENT_REGS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004

// control fields
`define CTRL_MODE_LSB 0
`define CTRL_BLOCK_LSB 2
`define CTRL_HYST_LSB 4
`define CTRL_EN_BIT 7
`define CTRL_UPDOWN_BIT 8
`define CTRL_THETA_LSB 9
`define CTRL_RANGE_LSB 16
`define CTRL_MASK 32'h0003_ffff
`define CTRL_RESET 32'h0000_0000

// status fields
`define STAT_CODE_LSB 0
`define STAT_INT_BIT 8

// ------------------------------------------------------------
// thresholds in 2g-range counts (1 mg nominal), shifted per range
// ------------------------------------------------------------
`define HYST_SHIFT_2G 4'd6
`define ACC_1G_2G 14'h0400
`define ACC_1G5_2G 14'h0600
`define SLOPE_0G2_2G 14'h00cd
`define SLOPE_0G4_2G 14'h019a
`define ZHYST_0G2_2G 14'h00cd

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_FREQ_KHZ 250000
`define STABLE_TIME_MS 100

`endif

/* File: pkg/orient_pkg.sv */
package orient_pkg;

   typedef enum logic [1:0] {
      MODE_SYM_A,
      MODE_HIGH_ASYM,
      MODE_LOW_ASYM,
      MODE_SYM_B
   } orient_mode_e;

   typedef enum logic [1:0] {
      BLOCK_NONE,
      BLOCK_THETA_ACC,
      BLOCK_THETA_SLOPE_ACC,
      BLOCK_THETA_SLOPE_STABLE
   } block_mode_e;

   typedef struct packed {
      logic valid;
      logic signed [11:0] x;
      logic signed [11:0] y;
      logic signed [11:0] z;
   } accel_sample_s;

   typedef struct packed {
      logic [1:0] g_range;
      logic [5:0] theta;
      logic updown_change_enable;
      logic orient_en;
      logic [2:0] hyst;
      block_mode_e blocking;
      orient_mode_e mode;
   } orient_ctrl_s;

endpackage

/* File: src/orientation_recognition_engine.sv */
`timescale 1ns/100ps
`include "orient_regs.svh"
module orientation_recognition_engine
   import orient_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = `STABLE_TIME_MS * `CLK_FREQ_KHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire accel_sample_s sample,
   input wire logic sleep_phase,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [2:0] orient_code,
   output logic orient_irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [31:0] ctrl_reg;
   orient_ctrl_s ctrl;
   logic [2:0] code_reg;
   logic int_reg;
   logic rep_z_reg;
   logic signed [11:0] prev_x_reg;
   logic signed [11:0] prev_y_reg;
   logic signed [11:0] prev_z_reg;
   logic prev_ok_reg;
   logic [24:0] stable_cnt_reg;

   // bit 15 is a gap in the register, so range is taken from 17:16
   assign ctrl = orient_ctrl_s'({ctrl_reg[17:16], ctrl_reg[14:0]});

   // ------------------------------------------------------------
   // apb slave, one wait state
   // ------------------------------------------------------------
   logic access;
   logic wr_commit;
   logic [31:0] rdata_next;
   logic err_next;

   assign access = psel & penable & ~pready;
   assign wr_commit = psel & penable & pready & pwrite;

   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      if (paddr == `REG_CTRL_OFS) begin
         rdata_next = ctrl_reg;
      end else if (paddr == `REG_STATUS_OFS) begin
         rdata_next[`STAT_CODE_LSB +: 3] = code_reg;
         rdata_next[`STAT_INT_BIT] = int_reg;
      end else begin
         err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         prdata <= access ? rdata_next : 32'h0000_0000;
         pslverr <= access & err_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_commit && paddr == `REG_CTRL_OFS) begin
         ctrl_reg <= pwdata & `CTRL_MASK;
      end
   end

   // ------------------------------------------------------------
   // classification
   // ------------------------------------------------------------
   function automatic logic [13:0] mag(input logic signed [11:0] v);
      logic [12:0] w;
      w = v[11] ? 13'(-$signed({v[11], v})) : {1'b0, v};
      return {1'b0, w};
   endfunction

   logic take;
   logic [13:0] ax;
   logic [13:0] ay;
   logic [13:0] az;
   logic [13:0] hyst;
   logic [13:0] xref;
   logic portrait;
   logic landscape;
   logic [1:0] xy_next;
   logic x_pos;
   logic x_neg;

   assign take = sample.valid & ~sleep_phase;
   assign ax = mag(sample.x);
   assign ay = mag(sample.y);
   assign az = mag(sample.z);
   // scale tracks range so 1 lsb is always 62.5 mg
   assign hyst = 14'({11'h000, ctrl.hyst} << (`HYST_SHIFT_2G - {2'b00, ctrl.g_range}));

   always_comb begin
      case (ctrl.mode)
         MODE_HIGH_ASYM: xref = {ax[12:0], 1'b0};
         MODE_LOW_ASYM: xref = {1'b0, ax[13:1]};
         default: xref = ax;
      endcase
   end

   // adding hyst on the other side avoids underflow of xref - hyst
   assign portrait = (ay + hyst) < xref;
   assign landscape = ay >= (xref + hyst);
   assign x_pos = $signed({2'b00, hyst}) <= $signed({sample.x[11], sample.x[11], sample.x});
   assign x_neg = ($signed({sample.x[11], sample.x[11], sample.x}) + $signed({2'b00, hyst}))
                  < $signed(16'sh0000);

   always_comb begin
      xy_next = code_reg[1:0];
      if (portrait && x_pos) begin
         xy_next = 2'b00;
      end else if (portrait && x_neg) begin
         xy_next = 2'b01;
      end else if (landscape) begin
         xy_next = sample.y[11] ? 2'b10 : 2'b11;
      end
   end

   // ------------------------------------------------------------
   // blocking
   // ------------------------------------------------------------
   logic [13:0] one_g;
   logic [10:0] sx;
   logic [10:0] sy;
   logic [10:0] sz;
   logic [29:0] xy_sq;
   logic [29:0] z_sq;
   logic theta_blk;
   logic over_acc;
   logic [13:0] slx;
   logic [13:0] sly;
   logic [13:0] slz;
   logic slope_lo;
   logic slope_hi;
   logic unstable;
   logic blocked;

   assign one_g = `ACC_1G_2G >> ctrl.g_range;
   // saturate at 1g so squares stay bounded; angles exact only at rest
   assign sx = 11'(ax > one_g ? one_g : ax);
   assign sy = 11'(ay > one_g ? one_g : ay);
   assign sz = 11'(az > one_g ? one_g : az);
   assign xy_sq = 30'({19'h0, sx} * {19'h0, sx}) + 30'({19'h0, sy} * {19'h0, sy});
   // tan^2 < theta/64  <=>  64(x^2+y^2) < theta*z^2
   assign z_sq = 30'({24'h0, ctrl.theta} * 30'({19'h0, sz} * {19'h0, sz}));
   assign theta_blk = {xy_sq[23:0], 6'h00} < z_sq;

   assign over_acc = (ax > (`ACC_1G5_2G >> ctrl.g_range)) ||
                     (ay > (`ACC_1G5_2G >> ctrl.g_range)) ||
                     (az > (`ACC_1G5_2G >> ctrl.g_range));
   assign slx = mag(12'(sample.x - prev_x_reg));
   assign sly = mag(12'(sample.y - prev_y_reg));
   assign slz = mag(12'(sample.z - prev_z_reg));
   assign slope_lo = prev_ok_reg && ((slx > (`SLOPE_0G2_2G >> ctrl.g_range)) ||
                     (sly > (`SLOPE_0G2_2G >> ctrl.g_range)) ||
                     (slz > (`SLOPE_0G2_2G >> ctrl.g_range)));
   assign slope_hi = prev_ok_reg && ((slx > (`SLOPE_0G4_2G >> ctrl.g_range)) ||
                     (sly > (`SLOPE_0G4_2G >> ctrl.g_range)) ||
                     (slz > (`SLOPE_0G4_2G >> ctrl.g_range)));
   assign unstable = stable_cnt_reg < 25'(STABLE_CYCLES);

   always_comb begin
      case (ctrl.blocking)
         BLOCK_THETA_ACC: blocked = theta_blk | over_acc;
         BLOCK_THETA_SLOPE_ACC: blocked = theta_blk | slope_lo | over_acc;
         BLOCK_THETA_SLOPE_STABLE: blocked = theta_blk | slope_hi | (over_acc & unstable);
         default: blocked = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // code, z hysteresis and interrupt
   // ------------------------------------------------------------
   logic update;
   logic z_qual;
   logic z_event;
   logic change;
   logic int_set;

   assign update = take & ~blocked;
   assign z_qual = az > (`ZHYST_0G2_2G >> ctrl.g_range);
   assign z_event = ctrl.updown_change_enable & z_qual & (sample.z[11] != rep_z_reg);
   assign change = (xy_next != code_reg[1:0]) | z_event;
   assign int_set = update & change & ctrl.orient_en;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_reg <= 3'h0;
      end else if (update) begin
         code_reg <= {sample.z[11], xy_next};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_z_reg <= 1'b0;
      end else if (update && z_qual) begin
         rep_z_reg <= sample.z[11];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_reg <= 1'b0;
      end else if (int_set) begin
         int_reg <= 1'b1;
      end else if (take && !change) begin
         int_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_cnt_reg <= 25'h0000000;
      end else if (update && ({sample.z[11], xy_next} != code_reg)) begin
         stable_cnt_reg <= 25'h0000000;
      end else if (unstable) begin
         stable_cnt_reg <= stable_cnt_reg + 25'h0000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_x_reg <= 12'sh000;
         prev_y_reg <= 12'sh000;
         prev_z_reg <= 12'sh000;
         prev_ok_reg <= 1'b0;
      end else if (take) begin
         prev_x_reg <= sample.x;
         prev_y_reg <= sample.y;
         prev_z_reg <= sample.z;
         prev_ok_reg <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         orient_code <= 3'h0;
         orient_irq <= 1'b0;
      end else begin
         orient_code <= code_reg;
         orient_irq <= int_reg;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence apb_access_s;
      psel && penable && !pready;
   endsequence

   sequence apb_answer_s;
      pready ##1 !pready;
   endsequence

   apb_one_wait_a: assert property (apb_access_s |=> apb_answer_s)
      else $error("apb answer not after one wait state");
   blocked_hold_a: assert property (take && blocked |=> $stable(code_reg))
      else $error("code changed on blocked sample");
   theta_block_a: assert property (take && ctrl.blocking != BLOCK_NONE && theta_blk
                                   |=> $stable(code_reg))
      else $error("theta condition did not block");
   z_bit_a: assert property (update |=> code_reg[2] == $past(sample.z[11]))
      else $error("z bit does not follow z sign");
   landscape_code_a: assert property (update && landscape |=> code_reg[1])
      else $error("landscape not coded");
   xy_keep_a: assert property (update && !portrait && !landscape
                               |=> code_reg[1:0] == $past(code_reg[1:0]))
      else $error("x-y bits moved in hysteresis band");
   irq_raise_a: assert property (int_set |=> int_reg ##1 orient_irq)
      else $error("code change raised no interrupt");
   irq_disabled_a: assert property (!ctrl.orient_en && !int_reg |=> !int_reg)
      else $error("interrupt raised while disabled");
   irq_clear_a: assert property (int_reg && take && !change |=> !int_reg ##1 !orient_irq)
      else $error("interrupt not cleared after stable sample");
   updown_mask_a: assert property (take && !ctrl.updown_change_enable
                                   && xy_next == code_reg[1:0] |=> !$rose(int_reg))
      else $error("z change raised interrupt with up-down disabled");

endmodule

/* File: verification/accel_source.sv */
`timescale 1ns/100ps
module accel_source
   import orient_pkg::*;
(
   input wire logic pclk,
   output accel_sample_s sample
);
   // ------------------------------------------------------------
   // sample strobe
   // ------------------------------------------------------------
   initial begin
      sample = '0;
   end

   // axes show the inverse once valid drops, so a stale word never passes as fresh
   task automatic send(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
      @(posedge pclk);
      sample <= '{1'b1, x, y, z};
      @(posedge pclk);
      sample <= '{1'b0, ~x, ~y, ~z};
   endtask
endmodule

/* File: verification/tb_orientation_recognition_engine.sv */
`timescale 1ns/100ps
module tb_orientation_recognition_engine
   import orient_pkg::*;
;
   typedef struct packed {
      logic [1:0] rng;
      logic [1:0] mode;
      logic [2:0] hy;
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic [2:0] c;
      logic q;
   } row_s;

   logic pclk, presetn, psel, penable, pwrite, sleep_phase, pready, pslverr, orient_irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] orient_code;
   accel_sample_s sample;
   int fail_count = 0;
   int total_checks = 0;
   int k;
   row_s rows [12] = '{
      '{2'd0, 2'd0, 3'd0, 12'd800, 12'd100, 12'd500, 3'h0, 1'b0},
      '{2'd0, 2'd0, 3'd0, -12'd800, 12'd100, 12'd500, 3'h1, 1'b1},
      '{2'd0, 2'd0, 3'd0, 12'd100, -12'd800, 12'd500, 3'h2, 1'b1},
      '{2'd0, 2'd0, 3'd0, 12'd100, 12'd800, -12'd500, 3'h7, 1'b1},
      '{2'd0, 2'd3, 3'd0, 12'd800, 12'd100, -12'd500, 3'h4, 1'b1},
      '{2'd0, 2'd1, 3'd0, 12'd300, 12'd500, 12'd500, 3'h0, 1'b0},
      '{2'd0, 2'd2, 3'd0, 12'd800, -12'd500, 12'd500, 3'h2, 1'b1},
      '{2'd0, 2'd0, 3'd1, 12'd500, 12'd460, 12'd500, 3'h2, 1'b0},
      '{2'd0, 2'd0, 3'd1, 12'd500, 12'd400, 12'd500, 3'h0, 1'b1},
      '{2'd0, 2'd0, 3'd2, -12'd200, 12'd50, 12'd500, 3'h1, 1'b1},
      '{2'd0, 2'd0, 3'd2, -12'd100, 12'd60, 12'd500, 3'h1, 1'b0},
      '{2'd1, 2'd0, 3'd1, 12'd500, 12'd440, 12'd500, 3'h0, 1'b1}
   };

   orientation_recognition_engine #(.STABLE_CYCLES(40)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .sample(sample), .sleep_phase(sleep_phase),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .orient_code(orient_code),
      .orient_irq(orient_irq));
   accel_source src (.pclk(pclk), .sample(sample));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z,
                      input logic [2:0] c, input logic q);
      src.send(x, y, z);
      repeat (3) @(posedge pclk);
      chk("orient_code", 32'(orient_code), 32'(c));
      chk("orient_irq", 32'(orient_irq), 32'(q));
   endtask

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin
      #400000;
      fail_count++;
      close_out();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      sleep_phase = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("status reset", rd, 32'h0);
      for (k = 0; k < 12; k++) begin
         apb(1'b1, 12'h000, {14'h0, rows[k].rng, 8'h00, 1'b1, rows[k].hy, 2'b00, rows[k].mode});
         smp(rows[k].x, rows[k].y, rows[k].z, rows[k].c, rows[k].q);
      end
      apb(1'b1, 12'h000, 32'h180);
      smp(12'd800, 12'd100, 12'd500, 3'h0, 1'b0);
      smp(12'd800, 12'd100, -12'd500, 3'h4, 1'b1);
      smp(12'd800, 12'd100, 12'd100, 3'h0, 1'b0);
      smp(12'd800, 12'd100, -12'd100, 3'h4, 1'b0);
      smp(-12'd800, 12'd100, -12'd100, 3'h5, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk("status", rd, 32'h105);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("status ro", rd, 32'h105);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b1, 12'h000, 32'hffff_ffff);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl mask", rd, 32'h0003_ffff);
      // host withdraws enable: codes still move, no interrupt
      apb(1'b1, 12'h000, 32'h0);
      smp(-12'd800, 12'd100, -12'd100, 3'h5, 1'b0);
      smp(12'd800, 12'd100, 12'd500, 3'h0, 1'b0);
      apb(1'b1, 12'h000, 32'h84);
      smp(12'd100, -12'd1700, 12'd500, 3'h0, 1'b0);
      smp(12'd100, -12'd800, 12'd500, 3'h2, 1'b1);
      apb(1'b1, 12'h000, 32'h88);
      smp(12'd800, 12'd100, 12'd500, 3'h2, 1'b1);
      smp(12'd800, 12'd100, 12'd500, 3'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h7e84);
      smp(12'd100, -12'd800, 12'd1000, 3'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h1084);
      smp(12'd100, -12'd800, 12'd1000, 3'h2, 1'b1);
      apb(1'b1, 12'h000, 32'h8c);
      smp(12'd1700, 12'd100, 12'd500, 3'h2, 1'b1);
      smp(12'd1700, 12'd100, 12'd500, 3'h2, 1'b1);
      repeat (50) @(posedge pclk);
      smp(12'd1700, 12'd100, 12'd500, 3'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h80);
      @(posedge pclk);
      sleep_phase <= 1'b1;
      smp(-12'd800, 12'd100, -12'd500, 3'h0, 1'b1);
      sleep_phase <= 1'b0;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("code in reset", 32'(orient_code), 32'h0);
      chk("irq in reset", 32'(orient_irq), 32'h0);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl after reset", rd, 32'h0);
      close_out();
   end
endmodule
